// ==== status_two_regs.vh ====
// register offsets, field positions, reset values and counts of the status block
`ifndef STATUS_TWO_REGS_VH
`define STATUS_TWO_REGS_VH

// byte offsets on the register bus
`define ADDR_STATUS_TWO     6'h00
`define ADDR_BUSY           6'h04
`define ADDR_CRC_START      6'h08
`define ADDR_CRC_END        6'h0c
`define ADDR_ERASE_SECTOR   6'h10
`define ADDR_COMMAND        6'h14

// status_two_volatile field positions
`define BIT_PROGRAM_SUSP    0
`define BIT_ERASE_SUSP      1
`define BIT_SECTOR_OK       2
`define BIT_CRC_ABORTED     3
`define BIT_CRC_SUSP        4
`define RSVD_VALUE          3'h0

// command register field positions
`define BIT_CMD_CRC_GO      0
`define BIT_CMD_EVAL_ERASE  1

// reset values
`define STATUS_TWO_RESET    8'h00
`define ADDR_REG_RESET      32'h0000_0000
`define SECTOR_REG_RESET    6'h00

// crc range: end must reach start plus this distance
`define CRC_MIN_SPAN        33'h0_0000_0003

// sector map geometry
`define SECTOR_BITS         6
`define SECTOR_COUNT        64

// bus responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// ==== crc_range_check.v ====
// range check that launches or aborts an integrity crc calculation
`timescale 1ns/1ps
module crc_range_check (
    input  wire        clk_i,
    input  wire        rst_b_i,
    input  wire        go_i,
    input  wire [31:0] start_addr_i,
    input  wire [31:0] end_addr_i,
    output reg         launch_o,
    output reg         abort_set_o,
    output reg         abort_clr_o
);
`include "status_two_regs.vh"

    wire [32:0] min_end;
    wire        span_ok;

    // widened sum so a start near the top cannot wrap round
    assign min_end = {1'b0, start_addr_i} + `CRC_MIN_SPAN;
    assign span_ok = ({1'b0, end_addr_i} >= min_end);

    // one decision per request: launch and clear, or abort only
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            launch_o    <= 1'b0;
            abort_set_o <= 1'b0;
            abort_clr_o <= 1'b0;
        end else begin
            launch_o    <= go_i & span_ok;    // R04
            abort_clr_o <= go_i & span_ok;    // R04
            abort_set_o <= go_i & ~span_ok;   // R03
        end
    end

endmodule // crc_range_check

// ==== sector_erase_map.v ====
// per-sector record of the last erase result, read by evaluate requests
`timescale 1ns/1ps
module sector_erase_map (
    input  wire       clk_i,
    input  wire       rst_b_i,
    input  wire       done_i,
    input  wire [5:0] done_sector_i,
    input  wire       done_ok_i,
    input  wire       eval_i,
    input  wire [5:0] eval_sector_i,
    output reg        eval_ok_o,
    output reg        eval_done_o
);
`include "status_two_regs.vh"

    reg  [`SECTOR_COUNT-1:0] ok_map_r;
    wire                     hit_now;

    // result bit per sector, cleared at reset so no sector reads as erased
    genvar g;
    generate
        for (g = 0; g < `SECTOR_COUNT; g = g + 1) begin : g_sector
            always @(posedge clk_i) begin
                if (!rst_b_i) begin
                    ok_map_r[g] <= 1'b0;
                end else if (done_i && done_sector_i == g) begin
                    ok_map_r[g] <= done_ok_i;
                end
            end
        end
    endgenerate

    // an erase finishing in the lookup cycle is forwarded, not missed
    assign hit_now = done_i && (done_sector_i == eval_sector_i);

    // lookup answers one cycle after the request
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            eval_ok_o   <= 1'b0;
            eval_done_o <= 1'b0;
        end else begin
            eval_done_o <= eval_i;
            if (eval_i) begin
                eval_ok_o <= hit_now ? done_ok_i
                                     : ok_map_r[eval_sector_i];   // R07
            end
        end
    end

endmodule // sector_erase_map

// ==== status_two_regs.v ====
// status register two with its axi4-lite slave, crc and erase-check control
//
// Functional notes
// R01: bits seven to five are reserved, read zero; host writes default.
// R02: bit four is one while the integrity crc is suspended.
// R03: crc request with end below start plus three sets abort, no run.
// R04: crc request with end at least start plus three clears abort.
// R05: bit three reports the crc abort flag, one meaning aborted.
// R06: host issues evaluate-erase-status with sector before reading bit two.
// R07: after evaluate, bit two is one if that sector erased successfully.
// R08: bit one is one while an erase is suspended, else zero.
// R09: bit zero is one while a program is suspended, else zero.
// R10: host trusts the register only while the busy flag reads zero.
// R11: busy flag is one during embedded operations, new requests refused.
// R12: register clears at reset; writes to its read-only bits are ignored.
`timescale 1ns/1ps
module status_two_regs (
    input  wire        clk_i,
    input  wire        rst_b_i,
    // axi4-lite slave
    input  wire [5:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [5:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // embedded operation engines
    input  wire        engine_busy_i,
    input  wire        crc_suspended_i,
    input  wire        erase_suspended_i,
    input  wire        program_suspended_i,
    input  wire        erase_done_i,
    input  wire [5:0]  erase_done_sector_i,
    input  wire        erase_done_ok_i,
    output wire        crc_launch_o,
    output wire [31:0] crc_start_address_o,
    output wire [31:0] crc_end_address_o,
    output wire        device_busy_flag_o,
    output wire [7:0]  status_two_volatile_o
);
`include "status_two_regs.vh"

    // ****************************************************************
    // storage
    // ****************************************************************
    reg  [5:0]  aw_addr_r;
    reg         aw_held_r;
    reg  [31:0] w_data_r;
    reg  [3:0]  w_strb_r;
    reg         w_held_r;
    reg  [31:0] crc_start_r;
    reg  [31:0] crc_end_r;
    reg  [5:0]  erase_sector_r;
    reg         crc_aborted_r;
    reg         sector_ok_r;
    reg         crc_susp_r;
    reg         erase_susp_r;
    reg         prog_susp_r;
    reg         crc_go_r;
    reg         eval_go_r;
    reg         crc_go_nxt;
    reg         eval_go_nxt;
    reg  [1:0]  wr_resp_nxt;
    reg  [31:0] rd_data_nxt;
    reg  [1:0]  rd_resp_nxt;
    wire        wr_fire;
    wire        rd_fire;
    wire        launch;
    wire        abort_set;
    wire        abort_clr;
    wire        eval_ok;
    wire        eval_done;
    wire        busy;
    wire [7:0]  status_two;

    // ****************************************************************
    // submodules
    // ****************************************************************
    crc_range_check u_crc_check (
        .clk_i        (clk_i),
        .rst_b_i      (rst_b_i),
        .go_i         (crc_go_r),
        .start_addr_i (crc_start_r),
        .end_addr_i   (crc_end_r),
        .launch_o     (launch),
        .abort_set_o  (abort_set),
        .abort_clr_o  (abort_clr)
    );

    sector_erase_map u_erase_map (
        .clk_i         (clk_i),
        .rst_b_i       (rst_b_i),
        .done_i        (erase_done_i),
        .done_sector_i (erase_done_sector_i),
        .done_ok_i     (erase_done_ok_i),
        .eval_i        (eval_go_r),
        .eval_sector_i (erase_sector_r),
        .eval_ok_o     (eval_ok),
        .eval_done_o   (eval_done)
    );

    // ****************************************************************
    // busy flag and status assembly
    // ****************************************************************
    // busy also covers the cycles a crc check or erase lookup is in flight
    assign busy = engine_busy_i | crc_go_r | eval_go_r
                | launch | abort_set | eval_done;               // R11

    assign device_busy_flag_o    = busy;                        // R11
    assign crc_launch_o          = launch;                      // R03
    assign crc_start_address_o   = crc_start_r;
    assign crc_end_address_o     = crc_end_r;

    // reserved bits are constants, nothing can load them
    assign status_two = {`RSVD_VALUE,                           // R01
                         crc_susp_r,                            // R02
                         crc_aborted_r,                         // R05
                         sector_ok_r,
                         erase_susp_r,
                         prog_susp_r};
    assign status_two_volatile_o = status_two;

    // suspend flags follow the engines' levels one clock later
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            crc_susp_r   <= 1'b0;                               // R12
            erase_susp_r <= 1'b0;
            prog_susp_r  <= 1'b0;
        end else begin
            crc_susp_r   <= crc_suspended_i;                    // R02
            erase_susp_r <= erase_suspended_i;                  // R08
            prog_susp_r  <= program_suspended_i;                // R09
        end
    end

    // abort flag and erase result; only hardware events touch them
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            crc_aborted_r <= 1'b0;                              // R12
            sector_ok_r   <= 1'b0;
        end else begin
            if (abort_set) begin
                crc_aborted_r <= 1'b1;                          // R03
            end else if (abort_clr) begin
                crc_aborted_r <= 1'b0;                          // R04
            end
            if (eval_done) begin
                sector_ok_r <= eval_ok;                         // R07
            end
        end
    end

    // ****************************************************************
    // axi4-lite write path
    // ****************************************************************
    // address and data are held separately, so either may come first
    assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid;
    assign wr_fire       = aw_held_r & w_held_r & ~s_axi_bvalid;

    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 6'h00;
            w_held_r  <= 1'b0;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // write decode: response code and command pulses
    always @* begin
        wr_resp_nxt = `RESP_OKAY;
        crc_go_nxt  = 1'b0;
        eval_go_nxt = 1'b0;
        if (aw_addr_r == `ADDR_STATUS_TWO) begin
            wr_resp_nxt = `RESP_OKAY;                           // R12
        end else if (aw_addr_r == `ADDR_BUSY) begin
            wr_resp_nxt = `RESP_OKAY;
        end else if (aw_addr_r == `ADDR_CRC_START) begin
            wr_resp_nxt = `RESP_OKAY;
        end else if (aw_addr_r == `ADDR_CRC_END) begin
            wr_resp_nxt = `RESP_OKAY;
        end else if (aw_addr_r == `ADDR_ERASE_SECTOR) begin
            wr_resp_nxt = `RESP_OKAY;
        end else if (aw_addr_r == `ADDR_COMMAND) begin
            // commands arriving while busy are dropped, not queued
            if (w_strb_r[0] && !busy) begin                     // R11
                crc_go_nxt  = w_data_r[`BIT_CMD_CRC_GO];
                eval_go_nxt = w_data_r[`BIT_CMD_EVAL_ERASE] &
                              ~w_data_r[`BIT_CMD_CRC_GO];
            end
        end else begin
            wr_resp_nxt = `RESP_SLVERR;
        end
    end

    // writable registers honour byte strobes
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            crc_start_r    <= `ADDR_REG_RESET;
            crc_end_r      <= `ADDR_REG_RESET;
            erase_sector_r <= `SECTOR_REG_RESET;
            crc_go_r       <= 1'b0;
            eval_go_r      <= 1'b0;
            s_axi_bvalid   <= 1'b0;
            s_axi_bresp    <= `RESP_OKAY;
        end else begin
            crc_go_r  <= wr_fire & crc_go_nxt;
            eval_go_r <= wr_fire & eval_go_nxt;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_resp_nxt;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_fire && aw_addr_r == `ADDR_CRC_START) begin
                if (w_strb_r[0]) crc_start_r[7:0]   <= w_data_r[7:0];
                if (w_strb_r[1]) crc_start_r[15:8]  <= w_data_r[15:8];
                if (w_strb_r[2]) crc_start_r[23:16] <= w_data_r[23:16];
                if (w_strb_r[3]) crc_start_r[31:24] <= w_data_r[31:24];
            end
            if (wr_fire && aw_addr_r == `ADDR_CRC_END) begin
                if (w_strb_r[0]) crc_end_r[7:0]   <= w_data_r[7:0];
                if (w_strb_r[1]) crc_end_r[15:8]  <= w_data_r[15:8];
                if (w_strb_r[2]) crc_end_r[23:16] <= w_data_r[23:16];
                if (w_strb_r[3]) crc_end_r[31:24] <= w_data_r[31:24];
            end
            // sector choice for the next evaluate request
            if (wr_fire && aw_addr_r == `ADDR_ERASE_SECTOR &&
                w_strb_r[0]) begin
                erase_sector_r <= w_data_r[5:0];                // R06
            end
        end
    end

    // ****************************************************************
    // axi4-lite read path
    // ****************************************************************
    assign s_axi_arready = ~s_axi_rvalid;
    assign rd_fire       = s_axi_arvalid & s_axi_arready;

    // read decode; narrow fields sit low, upper bits read zero
    always @* begin
        rd_data_nxt = 32'h0000_0000;
        rd_resp_nxt = `RESP_OKAY;
        if (s_axi_araddr == `ADDR_STATUS_TWO) begin
            rd_data_nxt = {24'h00_0000, status_two};            // R01
        end else if (s_axi_araddr == `ADDR_BUSY) begin
            rd_data_nxt = {31'h0000_0000, busy};                // R11
        end else if (s_axi_araddr == `ADDR_CRC_START) begin
            rd_data_nxt = crc_start_r;
        end else if (s_axi_araddr == `ADDR_CRC_END) begin
            rd_data_nxt = crc_end_r;
        end else if (s_axi_araddr == `ADDR_ERASE_SECTOR) begin
            rd_data_nxt = {26'h000_0000, erase_sector_r};
        end else if (s_axi_araddr == `ADDR_COMMAND) begin
            rd_data_nxt = 32'h0000_0000;    // commands are pulses
        end else begin
            rd_resp_nxt = `RESP_SLVERR;
        end
    end

    // read answer registered one cycle after the address is taken
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `RESP_OKAY;
        end else begin
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_data_nxt;
                s_axi_rresp  <= rd_resp_nxt;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // status_two_regs

// ==== status_two_asserts.sv ====
// checker on the ports of the status register two block
`timescale 1ns/1ps
module status_two_asserts (
    input wire        clk_i,
    input wire        rst_b_i,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire        engine_busy_i,
    input wire        crc_suspended_i,
    input wire        erase_suspended_i,
    input wire        program_suspended_i,
    input wire        crc_launch_o,
    input wire [31:0] crc_start_address_o,
    input wire [31:0] crc_end_address_o,
    input wire        device_busy_flag_o,
    input wire [7:0]  status_two_volatile_o
);
    // ********************************
    // properties
    // ********************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    wire [7:0] st = status_two_volatile_o;

    a_rsvd_zero: assert property (st[7:5] == 3'h0)
        else $error("reserved status bits not zero");
    a_crc_susp_bit: assert property ($past(rst_b_i) |->
        st[4] == $past(crc_suspended_i)) else $error("crc suspend bit");
    a_erase_susp_bit: assert property ($past(rst_b_i) |->
        st[1] == $past(erase_suspended_i)) else $error("erase suspend bit");
    a_prog_susp_bit: assert property ($past(rst_b_i) |->
        st[0] == $past(program_suspended_i)) else $error("program bit");
    // a launch needs end at least start plus three, 33-bit wide
    a_launch_range: assert property (crc_launch_o |->
        {1'b0, crc_end_address_o} >= {1'b0, crc_start_address_o} + 33'h3)
        else $error("crc launched on short range");
    a_abort_clears: assert property (crc_launch_o |=> !st[3])
        else $error("abort flag kept after launch");
    a_abort_no_run: assert property ($rose(st[3]) |->
        !$past(crc_launch_o)) else $error("abort set with launch");
    a_launch_pulse: assert property (crc_launch_o |=> !crc_launch_o)
        else $error("launch longer than one cycle");
    a_busy_on_run: assert property (crc_launch_o |->
        device_busy_flag_o && $past(device_busy_flag_o))
        else $error("not busy around launch");
    a_busy_engine: assert property (
        engine_busy_i |-> device_busy_flag_o)
        else $error("engine busy not reported");
    a_sector_quiet: assert property ($changed(st[2]) |->
        $past(device_busy_flag_o)) else $error("sector bit moved idle");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");

    c_launch: cover property (crc_launch_o);
    c_abort: cover property ($rose(st[3]));
    c_sector_ok: cover property ($rose(st[2]));
    c_crc_susp: cover property ($rose(st[4]));
endmodule // status_two_asserts

bind status_two_regs status_two_asserts i_status_two_asserts (.*);

// ==== flash_engine_model.sv ====
// engine model: crc busy span, suspend levels and erase results
`timescale 1ns/1ps
module flash_engine_model #(
    parameter BUSY_LEN = 20
) (
    input  wire       clk_i,
    input  wire       rst_b_i,
    input  wire       crc_launch_i,
    output reg        engine_busy_o,
    output reg        crc_suspended_o = 1'b0,
    output reg        erase_suspended_o = 1'b0,
    output reg        program_suspended_o = 1'b0,
    output reg        erase_done_o = 1'b0,
    output reg  [5:0] erase_done_sector_o = 6'h00,
    output reg        erase_done_ok_o = 1'b0
);
    integer left_r = 0;

    // a crc run holds the engine busy for a fixed span
    always @(posedge clk_i) begin
        if (!rst_b_i)
            left_r <= 0;
        else if (crc_launch_i)
            left_r <= BUSY_LEN;
        else if (left_r > 0)
            left_r <= left_r - 1;
    end
    always @* engine_busy_o = (left_r > 0);

    // suspend levels in order crc, erase, program
    task set_susp(input [2:0] s);
        begin
            @(posedge clk_i);
            {crc_suspended_o, erase_suspended_o, program_suspended_o} <= s;
        end
    endtask

    // one-cycle erase result; payload turns over once released
    task finish_erase(input [5:0] sec, input ok);
        begin
            @(posedge clk_i);
            erase_done_o <= 1'b1;
            erase_done_sector_o <= sec;
            erase_done_ok_o <= ok;
            @(posedge clk_i);
            erase_done_o <= 1'b0;
            erase_done_sector_o <= ~sec;
            erase_done_ok_o <= ~ok;
        end
    endtask
endmodule // flash_engine_model

// ==== status_two_regs_test.sv ====
// testbench for the status register two block
`timescale 1ns/1ps
`include "status_two_regs.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
    $display("FAIL %0t got %h exp %h", $time, (g), (e)); end end
module status_two_regs_test;
    reg         clk_i = 1'b0;
    reg         rst_b_i = 1'b0;
    reg  [5:0]  awaddr = 6'h00;
    reg  [5:0]  araddr = 6'h00;
    reg  [31:0] wdata = 32'h0;
    reg         awvalid = 1'b0;
    reg         wvalid = 1'b0;
    reg         bready = 1'b0;
    reg         arvalid = 1'b0;
    reg         rready = 1'b0;
    wire        awready, wready, bvalid, arready, rvalid;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata, cstart, cend;
    wire        busy, csus, esus, psus, edone, eok, launch, bflag;
    wire [5:0]  esec;
    wire [7:0]  status;
    integer     errors = 0;
    integer     n_compared = 0;
    integer     n_launch = 0;
    integer     i;
    reg  [31:0] d;
    reg  [1:0]  r;

    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) if (launch === 1'b1) n_launch++;

    status_two_regs i_status_two_regs (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .engine_busy_i(busy), .crc_suspended_i(csus),
        .erase_suspended_i(esus), .program_suspended_i(psus),
        .erase_done_i(edone), .erase_done_sector_i(esec),
        .erase_done_ok_i(eok), .crc_launch_o(launch),
        .crc_start_address_o(cstart), .crc_end_address_o(cend),
        .device_busy_flag_o(bflag), .status_two_volatile_o(status));

    flash_engine_model #(.BUSY_LEN(20)) i_flash_engine_model (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .crc_launch_i(launch),
        .engine_busy_o(busy), .crc_suspended_o(csus),
        .erase_suspended_o(esus), .program_suspended_o(psus),
        .erase_done_o(edone), .erase_done_sector_o(esec),
        .erase_done_ok_o(eok));

    // ********************************
    // bus tasks
    // ********************************
    // write: both halves offered together, each dropped when taken
    // ready is raised late on purpose so the response must hold a cycle
    task wr(input [5:0] a, input [31:0] v, input [1:0] exp_resp);
        begin
            @(posedge clk_i);
            awaddr <= a;
            wdata <= v;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            forever begin
                @(posedge clk_i);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
                if (bvalid === 1'b1 && bready) break;
                if (bvalid === 1'b1) bready <= 1'b1;
            end
            bready <= 1'b0;
            `CHK(bresp, exp_resp)
        end
    endtask

    task rd(input [5:0] a, output [31:0] v, output [1:0] rsp);
        begin
            @(posedge clk_i);
            araddr <= a;
            arvalid <= 1'b1;
            forever begin
                @(posedge clk_i);
                if (arready) arvalid <= 1'b0;
                if (rvalid === 1'b1 && rready) break;
                if (rvalid === 1'b1) rready <= 1'b1;
            end
            v = rdata;
            rsp = rresp;
            rready <= 1'b0;
        end
    endtask

    task rdc(input [5:0] a, input [31:0] e);
        begin
            rd(a, d, r);
            `CHK(d, e)
            `CHK(r, `RESP_OKAY)
        end
    endtask

    // status is only trusted once the busy flag reads zero
    task wait_idle;
        integer n;
        begin
            n = 0;
            d = 32'h1;
            while (d[0] !== 1'b0 && n < 100) begin
                rd(`ADDR_BUSY, d, r);
                n++;
            end
            `CHK(d[0], 1'b0)
        end
    endtask

    task close_out;
        begin
            if (errors == 0 && n_compared > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    // watchdog: the tests need well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        close_out;
    end

    // ********************************
    // tests
    // ********************************
    initial begin
        repeat (12) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rdc(`ADDR_STATUS_TWO, 32'h0);
        rdc(`ADDR_BUSY, 32'h0);
        wr(`ADDR_STATUS_TWO, 32'hffff_ffff, `RESP_OKAY);
        rdc(`ADDR_STATUS_TWO, 32'h0);
        for (i = 0; i < 8; i++) begin
            i_flash_engine_model.set_susp(i[2:0]);
            repeat (2) @(posedge clk_i);
            rdc(`ADDR_STATUS_TWO, {27'h0, i[2], 2'h0, i[1:0]});
        end
        i_flash_engine_model.set_susp(3'h0);
        // start plus three overflows 32 bits: must still abort
        wr(`ADDR_CRC_START, 32'hffff_fffe, `RESP_OKAY);
        wr(`ADDR_CRC_END, 32'hffff_ffff, `RESP_OKAY);
        wr(`ADDR_COMMAND, 32'h1, `RESP_OKAY);
        wait_idle;
        rdc(`ADDR_STATUS_TWO, 32'h8);
        wr(`ADDR_CRC_START, 32'h0000_0100, `RESP_OKAY);
        wr(`ADDR_CRC_END, 32'h0000_0103, `RESP_OKAY);
        wr(`ADDR_COMMAND, 32'h3, `RESP_OKAY);
        // short range sent while the engine runs is dropped
        wr(`ADDR_CRC_END, 32'h0000_0100, `RESP_OKAY);
        wr(`ADDR_COMMAND, 32'h1, `RESP_OKAY);
        wait_idle;
        rdc(`ADDR_STATUS_TWO, 32'h0);
        `CHK(n_launch, 1)
        wr(`ADDR_CRC_END, 32'h0000_0102, `RESP_OKAY);
        wr(`ADDR_COMMAND, 32'h1, `RESP_OKAY);
        wait_idle;
        rdc(`ADDR_STATUS_TWO, 32'h8);
        `CHK(n_launch, 1)
        `CHK(cstart, 32'h0000_0100)
        `CHK(cend, 32'h0000_0102)
        rdc(`ADDR_CRC_END, 32'h0000_0102);
        // sector five ok, six failed, seven never erased
        i_flash_engine_model.finish_erase(6'h05, 1'b1);
        i_flash_engine_model.finish_erase(6'h06, 1'b0);
        for (i = 0; i < 3; i++) begin
            wr(`ADDR_ERASE_SECTOR, 32'h5 + i, `RESP_OKAY);
            wr(`ADDR_COMMAND, 32'h2, `RESP_OKAY);
            wait_idle;
            rdc(`ADDR_STATUS_TWO, (i == 0) ? 32'hc : 32'h8);
        end
        rdc(`ADDR_ERASE_SECTOR, 32'h7);
        rd(6'h18, d, r);
        `CHK(r, `RESP_SLVERR)
        `CHK(d, 32'h0)
        wr(6'h18, 32'h1, `RESP_SLVERR);
        close_out;
    end
endmodule // status_two_regs_test
